// File: ppk_port_pins.sv
// Purpose: Port pin drivers, input enables, keypad wake flag and divided clock output.
// Assumes: pclk is the oscillator clock; pin_in arrives asynchronously from the pads.
// Notes:   Oscillator type and reset level are straps sampled once after reset release.
//
// Functional notes
// - Open drain: no pull-ups; pull-down only while latch holds zero.
// - Push-pull: strong pull-up stays on while latch holds one.
// - Two fixed port 1 pins are always open drain; latch one makes input.
// - Reset-shared pin is input only, enabled only with internal reset.
// - Crystal oscillator options disable both oscillator-shared port 2 pins.
// - Latches reset to the strap level; reset-high pins sit in quasi mode.
// - Port 2 mode register spare bits: Schmitt, timer toggle and clock-out enables.
// - One Schmitt select per port; fixed and reset-shared pins always Schmitt.
// - Each port 0 pin has its own keypad wake enable bit.
// - Any enabled port 0 pin low sets the keypad flag; interrupt if enabled.
// - Keypad flag is cleared only by software.
// - Keypad interrupt wakes the processor from Idle and Power Down.
// - Clock output only with RC oscillator or external clock input.
// - Enabled clock output runs while the oscillator runs, Idle included.
// - Clock output frequency is one sixth of the CPU clock.
// - External clock enters on input pin; output pin stays a port pin unless the clock output runs.
// - CPU clock divider register slows the CPU clock.
// - Oscillator type comes from nonvolatile configuration, not a register.
// - Two mode bits per pin: quasi, push-pull, input only, open drain.
// - Quasi mode: latch rise turns strong pull-up on for two CPU clocks.
// - Quasi-bidirectional is the default mode of every configurable pin.
module ppk_port_pins (
  // Clock and reset
  input  logic                pclk,
  input  logic                presetn,
  // APB slave
  input  logic                psel,
  input  logic                penable,
  input  logic                pwrite,
  input  logic [11:0]         paddr,
  input  logic [31:0]         pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  // Nonvolatile configuration
  input  ppk_pkg::ppk_cfg_t   user_config_word,
  // Power state
  input  logic                idle_mode,
  input  logic                power_down,
  // Pads
  input  logic [17:0]         pin_in,
  output ppk_pkg::ppk_drv_t   pad_drv,
  output logic [17:0]         pad_in_en,
  output logic [17:0]         pad_schmitt,
  // Clocks out
  output logic                cpu_clk_tick,
  output logic                clock_output_pin,
  output logic                clock_output_oe,
  // Side controls
  output logic                t0_toggle_en,
  output logic                t1_toggle_en,
  output logic                keypad_irq,
  output logic                wake_req
);
  import ppk_pkg::*;

  // ----------------------------------------------------------------
  // Pad input synchronisers and strap capture
  // ----------------------------------------------------------------
  logic [NPINS-1:0] pin_meta_ff;
  logic [NPINS-1:0] pin_sync_ff;
  logic             cfg_loaded_ff;
  ppk_cfg_t         cfg_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_ff <= '1;
      pin_sync_ff <= '1;
    end else begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // The strap is taken on the first edge after release, never under the reset itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_loaded_ff <= 1'b0;
      cfg_ff        <= CFG_RST;
    end else if (!cfg_loaded_ff) begin
      cfg_loaded_ff <= 1'b1;
      cfg_ff        <= user_config_word;
    end
  end

  wire xtal_w = ppk_is_xtal(cfg_ff.osc_type);
  wire ext_w  = (cfg_ff.osc_type == OSC_EXT);
  wire rc_w   = (cfg_ff.osc_type == OSC_RC);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;

  wire setup_w  = psel & ~penable;
  wire wr_w     = psel & penable & pready_ff & pwrite;
  wire hit_l0   = addr_hit(paddr, ADDR_P0_LATCH);
  wire hit_l1   = addr_hit(paddr, ADDR_P1_LATCH);
  wire hit_l2   = addr_hit(paddr, ADDR_P2_LATCH);
  wire hit_m0l  = addr_hit(paddr, ADDR_P0_MODE_L);
  wire hit_m0h  = addr_hit(paddr, ADDR_P0_MODE_H);
  wire hit_m1l  = addr_hit(paddr, ADDR_P1_MODE_L);
  wire hit_m1h  = addr_hit(paddr, ADDR_P1_MODE_H);
  wire hit_port2_mode_reg_one = addr_hit(paddr, ADDR_P2_MODE1);
  wire hit_m2h  = addr_hit(paddr, ADDR_P2_MODE_H);
  wire hit_kbi  = addr_hit(paddr, ADDR_KBD_EN);
  wire hit_aux  = addr_hit(paddr, ADDR_AUX_CTRL);
  wire hit_div  = addr_hit(paddr, ADDR_CPU_DIV);
  wire hit_stat = addr_hit(paddr, ADDR_PIN_STAT);
  wire mapped_w = hit_l0 | hit_l1 | hit_l2 | hit_m0l | hit_m0h | hit_m1l | hit_m1h |
                  hit_port2_mode_reg_one | hit_m2h | hit_kbi | hit_aux | hit_div | hit_stat;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [NPINS-1:0] latch_ff;
  logic [NPINS-1:0] latch_prev_ff;
  logic [7:0]       m1_p0_ff;
  logic [7:0]       m2_p0_ff;
  logic [7:0]       m1_p1_ff;
  logic [7:0]       m2_p1_ff;
  logic [7:0]       port2_mode_reg_one_ff;
  logic [1:0]       p2m2_ff;
  logic [7:0]       kbi_ff;
  logic             kie_ff;
  logic             kbf_ff;
  logic [7:0]       cpu_clock_divider_ff;
  logic [NPINS-1:0] nxt_latch;
  logic             nxt_kbf;

  // On the edge that lands the strap, every latch takes the selected reset level.
  assign nxt_latch = !cfg_loaded_ff ? {NPINS{user_config_word.port_reset_level_select}} :
                     {(wr_w & hit_l2) ? pwdata[1:0] : latch_ff[17:16],
                      (wr_w & hit_l1) ? pwdata[7:0] : latch_ff[15:8],
                      (wr_w & hit_l0) ? pwdata[7:0] : latch_ff[7:0]};

  // Mode registers reset to all zero, which is the quasi-bidirectional code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_ff      <= LATCH_RST;
      latch_prev_ff <= LATCH_RST;
      m1_p0_ff      <= MODE_RST;
      m2_p0_ff      <= MODE_RST;
      m1_p1_ff      <= MODE_RST;
      m2_p1_ff      <= MODE_RST;
      port2_mode_reg_one_ff       <= PORT2_MODE_REG_ONE_RST;
      p2m2_ff       <= MODE_RST[1:0];
      kbi_ff        <= KBI_RST;
      kie_ff        <= 1'b0;
      cpu_clock_divider_ff       <= CPU_CLOCK_DIVIDER_RST;
    end else begin
      latch_ff      <= nxt_latch;
      latch_prev_ff <= latch_ff;
      if (wr_w & hit_m0l) m1_p0_ff <= pwdata[7:0];
      if (wr_w & hit_m0h) m2_p0_ff <= pwdata[7:0];
      if (wr_w & hit_m1l) m1_p1_ff <= pwdata[7:0];
      if (wr_w & hit_m1h) m2_p1_ff <= pwdata[7:0];
      if (wr_w & hit_port2_mode_reg_one) port2_mode_reg_one_ff <= pwdata[7:0];
      if (wr_w & hit_m2h) p2m2_ff <= pwdata[1:0];
      if (wr_w & hit_kbi) kbi_ff <= pwdata[7:0];
      if (wr_w & hit_aux) kie_ff <= pwdata[AUX_KIE_BIT];
      if (wr_w & hit_div) cpu_clock_divider_ff <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Keypad wake
  // ----------------------------------------------------------------
  // Detection needs pclk; a design that gates pclk in Power Down must keep it for this block.
  wire kbd_hit_w = |(kbi_ff & ~pin_sync_ff[7:0]);
  wire kbf_clr_w = wr_w & hit_aux & ~pwdata[AUX_KBF_BIT];

  // A new hit in the clearing cycle keeps the flag set.
  assign nxt_kbf = kbd_hit_w | (kbf_ff & ~kbf_clr_w);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kbf_ff <= 1'b0;
    end else begin
      kbf_ff <= nxt_kbf;
    end
  end

  // ----------------------------------------------------------------
  // CPU clock divider and clock output
  // ----------------------------------------------------------------
  logic [8:0] div_cnt_ff;
  logic [8:0] nxt_div_cnt;
  logic [1:0] co_cnt_ff;
  logic       co_lvl_ff;
  logic       co_oe_ff;
  logic       tick_ff;

  // Divide by 2*(N+1) for N > 0, so the last count is 2N+1.
  wire [8:0] div_last_w = (cpu_clock_divider_ff == 8'h00) ? 9'h000 : {cpu_clock_divider_ff, 1'b1};
  wire       tick_w     = ~power_down & (div_cnt_ff == div_last_w);
  wire       co_run_w   = port2_mode_reg_one_ff[PORT2_MODE_REG_ONE_CLKEN_BIT] & (rc_w | ext_w) & ~power_down;

  assign nxt_div_cnt = power_down ? div_cnt_ff :
                       (div_cnt_ff >= div_last_w) ? 9'h000 : 9'(div_cnt_ff + 9'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 9'h000;
      tick_ff    <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      tick_ff    <= tick_w;
    end
  end

  // The level flips every third CPU clock, giving one sixth of the CPU rate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      co_cnt_ff <= 2'h0;
      co_lvl_ff <= 1'b0;
      co_oe_ff  <= 1'b0;
    end else begin
      co_oe_ff <= co_run_w;
      if (!co_run_w) begin
        co_cnt_ff <= 2'h0;
        co_lvl_ff <= 1'b0;
      end else if (tick_w && co_cnt_ff == CLKOUT_HALF_M1) begin
        co_cnt_ff <= 2'h0;
        co_lvl_ff <= ~co_lvl_ff;
      end else if (tick_w) begin
        co_cnt_ff <= 2'(co_cnt_ff + 2'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-pin drivers
  // ----------------------------------------------------------------
  wire [NPINS-1:0] mode_lo_w = {port2_mode_reg_one_ff[1:0], m1_p1_ff, m1_p0_ff};
  wire [NPINS-1:0] mode_hi_w = {p2m2_ff, m2_p1_ff, m2_p0_ff};

  logic [NPINS-1:0] dis_w;
  logic [NPINS-1:0] in_en_w;
  logic [NPINS-1:0] od_w;
  logic [NPINS-1:0] pp_on_w;
  logic [NPINS-1:0] rise_w;
  ppk_drv_t         nxt_drv;
  logic [NPINS-1:0] nxt_sch;
  ppk_drv_t         pad_drv_ff;
  logic [NPINS-1:0] pad_in_en_ff;
  logic [NPINS-1:0] pad_schmitt_ff;

  function automatic ppk_mode_t eff_mode(input int idx, input logic lo, input logic hi);
    if (idx == PIN_FOD_A || idx == PIN_FOD_B) begin
      return MODE_OD;
    end else if (idx == PIN_RST_IN) begin
      return MODE_INPUT;
    end
    return ppk_mode_t'({lo, hi});
  endfunction

  function automatic logic port_sch(input int idx, input logic [7:0] port2_mode_reg_one);
    if (idx == PIN_FOD_A || idx == PIN_FOD_B || idx == PIN_RST_IN) begin
      return 1'b1;
    end else if (idx < P1_BASE) begin
      return port2_mode_reg_one[PORT2_MODE_REG_ONE_SCH0_BIT];
    end else if (idx < P2_BASE) begin
      return port2_mode_reg_one[PORT2_MODE_REG_ONE_SCH1_BIT];
    end
    return port2_mode_reg_one[PORT2_MODE_REG_ONE_SCH2_BIT];
  endfunction

  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    logic [1:0] cnt_ff;
    ppk_mode_t  mode_w;

    assign mode_w = eff_mode(i, mode_lo_w[i], mode_hi_w[i]);
    // Crystal modes take both port 2 pins; an external clock takes the input pin and
    // a running clock output owns the output pin.
    assign dis_w[i] = (i >= P2_BASE && xtal_w) | (i == PIN_OSC_IN && ext_w) |
                      (i == PIN_OSC_OUT && co_run_w);
    assign in_en_w[i] = ~dis_w[i] & ((i != PIN_RST_IN) | cfg_ff.internal_reset);
    assign od_w[i]    = (mode_w == MODE_OD);
    assign pp_on_w[i] = (mode_w == MODE_PP) & latch_ff[i] & ~dis_w[i];
    assign rise_w[i]  = latch_ff[i] & ~latch_prev_ff[i] & (mode_w == MODE_QUASI) & ~dis_w[i];

    // The pulse is counted in CPU clocks, so it stretches with the divider.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_ff <= 2'h0;
      end else if (rise_w[i]) begin
        cnt_ff <= QB_STRONG_TICKS;
      end else if (tick_w && cnt_ff != 2'h0) begin
        cnt_ff <= 2'(cnt_ff - 2'h1);
      end
    end

    // All output modes share one pull-down; input-only never pulls down.
    assign nxt_drv.pull_down[i] = ~dis_w[i] & ~latch_ff[i] & (mode_w != MODE_INPUT);
    assign nxt_drv.strong_up[i] = ~dis_w[i] & latch_ff[i] &
                                  ((mode_w == MODE_PP) |
                                   ((mode_w == MODE_QUASI) & (cnt_ff != 2'h0)));
    assign nxt_drv.weak_up[i]   = ~dis_w[i] & latch_ff[i] & (mode_w == MODE_QUASI) &
                                  pin_sync_ff[i];
    assign nxt_drv.very_weak_up[i] = ~dis_w[i] & latch_ff[i] & (mode_w == MODE_QUASI);
    assign nxt_sch[i] = port_sch(i, port2_mode_reg_one_ff);
  end

  // ----------------------------------------------------------------
  // Output registers and APB answer
  // ----------------------------------------------------------------
  wire [31:0] rd_w =
    hit_l0   ? {24'h0, latch_ff[7:0]} :
    hit_l1   ? {24'h0, latch_ff[15:8]} :
    hit_l2   ? {30'h0, latch_ff[17:16]} :
    hit_m0l  ? {24'h0, m1_p0_ff} :
    hit_m0h  ? {24'h0, m2_p0_ff} :
    hit_m1l  ? {24'h0, m1_p1_ff} :
    hit_m1h  ? {24'h0, m2_p1_ff} :
    hit_port2_mode_reg_one ? {24'h0, port2_mode_reg_one_ff} :
    hit_m2h  ? {30'h0, p2m2_ff} :
    hit_kbi  ? {24'h0, kbi_ff} :
    hit_aux  ? {30'h0, kbf_ff, kie_ff} :
    hit_div  ? {24'h0, cpu_clock_divider_ff} :
    hit_stat ? {14'h0, pin_sync_ff & in_en_w} : 32'h0;

  logic t0_ff;
  logic t1_ff;
  logic irq_ff;
  logic wake_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff      <= 1'b0;
      pslverr_ff     <= 1'b0;
      prdata_ff      <= 32'h0;
      pad_drv_ff     <= '0;
      pad_in_en_ff   <= '0;
      pad_schmitt_ff <= '0;
      t0_ff          <= 1'b0;
      t1_ff          <= 1'b0;
      irq_ff         <= 1'b0;
      wake_ff        <= 1'b0;
    end else begin
      pready_ff      <= setup_w;
      pslverr_ff     <= setup_w & ~mapped_w;
      prdata_ff      <= (setup_w & ~pwrite) ? rd_w : 32'h0;
      pad_drv_ff     <= nxt_drv;
      pad_in_en_ff   <= in_en_w;
      pad_schmitt_ff <= nxt_sch;
      t0_ff          <= port2_mode_reg_one_ff[PORT2_MODE_REG_ONE_TOG0_BIT];
      t1_ff          <= port2_mode_reg_one_ff[PORT2_MODE_REG_ONE_TOG1_BIT];
      irq_ff         <= kbf_ff & kie_ff;
      wake_ff        <= kbf_ff & kie_ff & (idle_mode | power_down);
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign pad_drv          = pad_drv_ff;
  assign pad_in_en        = pad_in_en_ff;
  assign pad_schmitt      = pad_schmitt_ff;
  assign cpu_clk_tick     = tick_ff;
  assign clock_output_pin = co_lvl_ff;
  assign clock_output_oe  = co_oe_ff;
  assign t0_toggle_en     = t0_ff;
  assign t1_toggle_en     = t1_ff;
  assign keypad_irq       = irq_ff;
  assign wake_req         = wake_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire cpu_clock_divider_zero_w = (cpu_clock_divider_ff == 8'h00);

  sequence s_qb_rise;
    rise_w[0] && cpu_clock_divider_zero_w;
  endsequence
  sequence s_qb_hold;
    (latch_ff[0] && !od_w[0] && mode_lo_w[0] == 1'b0 && mode_hi_w[0] == 1'b0 &&
     cpu_clock_divider_zero_w && !power_down)[*4];
  endsequence
  sequence s_co_steady;
    (co_run_w && cpu_clock_divider_zero_w)[*4];
  endsequence

  chk_od_pullups_off: assert property (
    ~|(pad_drv_ff.strong_up & $past(od_w)) && ~|(pad_drv_ff.very_weak_up & $past(od_w)) &&
    ~|(pad_drv_ff.pull_down & $past(od_w) & $past(latch_ff)))
    else $error("open drain pin shows a pull-up or a pull-down with latch high");
  chk_pp_strong_on: assert property (
    (pad_drv_ff.strong_up & $past(pp_on_w)) == $past(pp_on_w))
    else $error("push-pull pin with latch high lacks strong pull-up");
  chk_fixed_od_pins: assert property (
    !pad_drv_ff.strong_up[PIN_FOD_A] && !pad_drv_ff.very_weak_up[PIN_FOD_B] &&
    pad_drv_ff.pull_down[PIN_FOD_A] == !$past(latch_ff[PIN_FOD_A]))
    else $error("fixed open drain pin not driven as open drain");
  chk_reset_pin_input: assert property (
    !$past(cfg_ff.internal_reset) |-> !pad_in_en[PIN_RST_IN] && !pad_drv.pull_down[PIN_RST_IN])
    else $error("reset-shared pin enabled while external reset is used");
  chk_xtal_pins_off: assert property (
    $past(xtal_w) |-> pad_in_en[17:16] == 2'h0 && pad_drv.pull_down[17:16] == 2'h0 &&
                      pad_drv.very_weak_up[17:16] == 2'h0)
    else $error("oscillator-shared pins active with a crystal option");
  chk_qb_pulse_len: assert property (
    s_qb_rise ##1 s_qb_hold |-> !pad_drv.strong_up[0] && $past(pad_drv.strong_up[0]) &&
                                $past(pad_drv.strong_up[0], 2) && !$past(pad_drv.strong_up[0], 3))
    else $error("quasi strong pull-up pulse is not two CPU clocks");
  chk_kbf_sets: assert property (kbd_hit_w |=> kbf_ff)
    else $error("enabled keypad pin low did not set the flag");
  chk_kbf_sticky: assert property (kbf_ff && !kbf_clr_w |=> kbf_ff)
    else $error("keypad flag cleared without a software write");
  chk_kbd_wake: assert property (
    kbf_ff && kie_ff && (idle_mode || power_down) |=> keypad_irq && wake_req)
    else $error("keypad interrupt did not raise a wake request");
  chk_clkout_period: assert property (
    $rose(clock_output_pin) ##0 s_co_steady |-> !clock_output_pin &&
      $past(clock_output_pin) && $past(clock_output_pin, 2))
    else $error("clock output high phase is not three CPU clocks");
  chk_clkout_gated: assert property ($past(xtal_w) |-> !clock_output_oe)
    else $error("clock output enabled with a crystal option");

endmodule

// File: ppk_pkg.sv
// Purpose: Shared constants, register map and types for the port pin and keypad wake block.
// Assumes: 18 pins: port 0 is index 0..7, port 1 is 8..15, port 2 is 16..17.
// Notes:   Register offsets are byte addresses of aligned 32-bit words on APB.
package ppk_pkg;

  // ----------------------------------------------------------------
  // Pin geometry
  // ----------------------------------------------------------------
  localparam int NPINS       = 18;
  localparam int P1_BASE     = 8;
  localparam int P2_BASE     = 16;
  localparam int PIN_FOD_A   = 10;
  localparam int PIN_FOD_B   = 11;
  localparam int PIN_RST_IN  = 13;
  localparam int PIN_OSC_OUT = 16;
  localparam int PIN_OSC_IN  = 17;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_P0_LATCH  = 12'h000;
  localparam logic [11:0] ADDR_P1_LATCH  = 12'h004;
  localparam logic [11:0] ADDR_P2_LATCH  = 12'h008;
  localparam logic [11:0] ADDR_P0_MODE_L = 12'h00c;
  localparam logic [11:0] ADDR_P0_MODE_H = 12'h010;
  localparam logic [11:0] ADDR_P1_MODE_L = 12'h014;
  localparam logic [11:0] ADDR_P1_MODE_H = 12'h018;
  localparam logic [11:0] ADDR_P2_MODE1  = 12'h01c;
  localparam logic [11:0] ADDR_P2_MODE_H = 12'h020;
  localparam logic [11:0] ADDR_KBD_EN    = 12'h024;
  localparam logic [11:0] ADDR_AUX_CTRL  = 12'h028;
  localparam logic [11:0] ADDR_CPU_DIV   = 12'h02c;
  localparam logic [11:0] ADDR_PIN_STAT  = 12'h030;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AUX_KIE_BIT    = 0;
  localparam int AUX_KBF_BIT    = 1;
  localparam int PORT2_MODE_REG_ONE_TOG0_BIT  = 2;
  localparam int PORT2_MODE_REG_ONE_TOG1_BIT  = 3;
  localparam int PORT2_MODE_REG_ONE_SCH0_BIT  = 4;
  localparam int PORT2_MODE_REG_ONE_SCH1_BIT  = 5;
  localparam int PORT2_MODE_REG_ONE_SCH2_BIT  = 6;
  localparam int PORT2_MODE_REG_ONE_CLKEN_BIT = 7;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0]       MODE_RST  = 8'h00;
  localparam logic [7:0]       PORT2_MODE_REG_ONE_RST  = 8'h00;
  localparam logic [7:0]       KBI_RST   = 8'h00;
  localparam logic [7:0]       CPU_CLOCK_DIVIDER_RST  = 8'h00;
  localparam logic [NPINS-1:0] LATCH_RST = 18'h3ffff;
  localparam logic [1:0]       QB_STRONG_TICKS = 2'h2;
  localparam int               CLKOUT_DIV      = 6;
  localparam logic [1:0]       CLKOUT_HALF_M1  = 2'(CLKOUT_DIV / 2 - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OSC_XTAL_LOW  = 3'h0,
    OSC_XTAL_MED  = 3'h1,
    OSC_XTAL_HIGH = 3'h3,
    OSC_RC        = 3'h2,
    OSC_EXT       = 3'h6
  } ppk_osc_t;

  typedef enum logic [1:0] {
    MODE_QUASI = 2'h0,
    MODE_PP    = 2'h1,
    MODE_INPUT = 2'h2,
    MODE_OD    = 2'h3
  } ppk_mode_t;

  typedef struct packed {
    ppk_osc_t osc_type;
    logic     port_reset_level_select;
    logic     internal_reset;
  } ppk_cfg_t;

  typedef struct packed {
    logic [NPINS-1:0] pull_down;
    logic [NPINS-1:0] strong_up;
    logic [NPINS-1:0] weak_up;
    logic [NPINS-1:0] very_weak_up;
  } ppk_drv_t;

  localparam ppk_cfg_t CFG_RST = '{osc_type: OSC_RC, port_reset_level_select: 1'b1,
                                   internal_reset: 1'b0};

  function automatic logic ppk_is_xtal(input ppk_osc_t osc);
    return (osc == OSC_XTAL_LOW) || (osc == OSC_XTAL_MED) || (osc == OSC_XTAL_HIGH);
  endfunction

endpackage

// File: ppk_keypad_model.sv
// Purpose: Keypad switches and resistor loads on the port pins.
// Assumes: Every pin has an external resistor pull-up.
// Notes:   A pressed key or the pad pull-down wins over the resistor.
module ppk_keypad_model (
  // Pads
  input  ppk_pkg::ppk_drv_t pad_drv,
  input  logic [7:0]        key_low,
  output logic [17:0]       pin_in
);
  import ppk_pkg::*;
  // A floating pin would read unknown, so the resistor always sets the idle level.
  assign pin_in = ~(pad_drv.pull_down | {10'h000, key_low});
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for the port pin and keypad wake block.
// Assumes: RC strap resetting high, then a mid-run reset with a crystal strap resetting low.
// Notes:   Reads are queued by the driver and checked by a monitor.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ppk_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, idle_mode, pd;
  logic        pready, pslverr, clk_o, clk_oe, t0, t1, kirq, wake, tick;
  logic [11:0] paddr, v;
  logic [31:0] pwdata, prdata, kb;
  logic [7:0]  key_low;
  logic [17:0] pin_in, in_en, schm;
  ppk_drv_t    drv;
  ppk_cfg_t    cfg;
  logic [32:0] exp_q[$];
  int          n_fail = 0;
  int          samples_checked = 0;
  ppk_port_pins u_ppk_port_pins (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .user_config_word(cfg), .idle_mode(idle_mode),
    .power_down(pd), .pin_in(pin_in), .pad_drv(drv), .pad_in_en(in_en),
    .pad_schmitt(schm), .cpu_clk_tick(tick), .clock_output_pin(clk_o), .clock_output_oe(clk_oe),
    .t0_toggle_en(t0), .t1_toggle_en(t1), .keypad_irq(kirq), .wake_req(wake));
  ppk_keypad_model u_ppk_keypad_model (.pad_drv(drv), .key_low(key_low), .pin_in(pin_in));
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #20000;
    n_fail++;
    conclude();
  end
  initial begin
    {presetn, psel, penable, pwrite, idle_mode, pd, key_low, paddr, pwdata} = '0;
    cfg = CFG_RST;
    void'($urandom(32'hd8d3));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_P0_LATCH, 33'h0ff);
    rd(ADDR_P1_MODE_L, 33'h0);
    rd(12'h040, {1'b1, 32'h0});
    // Pin 1 is pulled low as an open-drain output below, so it stays out of the wake set.
    kb = ($urandom & 32'hfd) | 32'h1;
    xfer(1'b1, ADDR_KBD_EN, kb);
    rd(ADDR_KBD_EN, {1'b0, kb});
    xfer(1'b1, ADDR_P0_MODE_L, 32'h02);
    xfer(1'b1, ADDR_P0_MODE_H, 32'h06);
    xfer(1'b1, ADDR_P0_LATCH, 32'hfd);
    xfer(1'b1, ADDR_P1_MODE_H, 32'h04);
    repeat (3) @(posedge pclk);
    chk(33'({drv.pull_down[1], drv.strong_up[1], drv.weak_up[1], drv.very_weak_up[1]}), 33'h8);
    chk(33'(drv.strong_up[2]), 33'h1);
    chk(33'({drv.strong_up[10], schm[10], schm[13]}), 33'h3);
    xfer(1'b1, ADDR_AUX_CTRL, 32'h1);
    idle_mode <= 1'b1;
    key_low <= 8'h01;
    repeat (8) @(posedge pclk);
    chk(33'({kirq, wake}), 33'h3);
    key_low <= 8'h00;
    repeat (4) @(posedge pclk);
    {idle_mode, pd} <= 2'b01;
    repeat (2) @(posedge pclk);
    chk(33'(wake), 33'h1);
    {idle_mode, pd} <= 2'b10;
    rd(ADDR_AUX_CTRL, 33'h3);
    xfer(1'b1, ADDR_AUX_CTRL, 32'h1);
    rd(ADDR_AUX_CTRL, 33'h1);
    xfer(1'b1, ADDR_P2_MODE1, 32'h8c);
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 12; i++) begin
      @(posedge pclk);
      v[i] = clk_o;
    end
    chk(33'({clk_oe, t0, t1, v[8:0]}), 33'({3'h7, ~v[11:3]}));
    chk(33'($countones(v)), 33'h6);
    xfer(1'b1, ADDR_P2_MODE1, 32'h0c);
    xfer(1'b1, ADDR_P0_LATCH, 32'hfc);
    xfer(1'b1, ADDR_P0_LATCH, 32'hfd);
    repeat (2) @(posedge pclk);
    chk(33'(drv.strong_up[0]), 33'h1);
    repeat (2) @(posedge pclk);
    chk(33'({drv.strong_up[0], clk_oe, t0, t1, tick}), 33'h7);
    presetn <= 1'b0;
    cfg <= '{osc_type: OSC_XTAL_HIGH, port_reset_level_select: 1'b0, internal_reset: 1'b1};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_P0_LATCH, 33'h0);
    xfer(1'b1, ADDR_P2_MODE1, 32'h80);
    repeat (2) @(posedge pclk);
    chk(33'({in_en[17:16], in_en[13], drv.pull_down[17:16], clk_oe}), 33'h8);
    conclude();
  end
endmodule
